// ---- sfpc_pkg.sv ----
// Constants, types and field layout for the switch forwarding policy block.
// Assumes a single clock domain and an AHB-Lite register slave in front.
package sfpc_pkg;

  localparam logic [31:0] SFPC_CTL_ADDR = 32'h0000_0000;
  localparam logic [31:0] SFPC_STAT_ADDR = 32'h0000_0004;
  localparam logic [31:0] SFPC_CNT_ADDR = 32'h0000_0008;

  localparam int SFPC_INIT_SKIP_BIT = 6;
  localparam int SFPC_RO_DIS_BIT = 7;
  localparam int SFPC_P2P_DIS_BIT = 8;
  localparam int SFPC_DEVNUM_LSB = 9;
  localparam int SFPC_UPID_BIT = 11;
  localparam int SFPC_CT_DIS_BIT = 14;
  localparam int SFPC_LOCK_IGN_BIT = 15;
  localparam int SFPC_BCAST_BIT = 19;

  localparam logic [31:0] SFPC_CTL_WMASK = 32'h0008_cfc0;
  localparam logic [31:0] SFPC_CTL_RESET = 32'h0000_0000;

  localparam int SFPC_NPORTS = 6;
  localparam int SFPC_PORT_W = 3;
  localparam logic [SFPC_PORT_W-1:0] SFPC_UP_PORT = 3'h0;

  localparam logic [1:0] SFPC_DN_ALL = 2'h0;
  localparam logic [1:0] SFPC_DN_CFG = 2'h1;
  localparam logic [1:0] SFPC_DN_NONE = 2'h2;

  localparam logic [1:0] SFPC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] SFPC_HTRANS_SEQ = 2'h3;
  localparam int SFPC_REG_DEPTH = 4;
  localparam int SFPC_REG_AW = 2;

  // Routing verdict for a packet header
  typedef enum logic [1:0] {
    SFPC_FWD = 2'b00,
    SFPC_UR = 2'b01,
    SFPC_DROP = 2'b10
  } sfpc_verdict_t;

  // Hot reset sequence states
  typedef enum logic [1:0] {
    SFPC_HR_IDLE = 2'b00,
    SFPC_HR_LOAD = 2'b01,
    SFPC_HR_DONE = 2'b10
  } sfpc_hr_t;

endpackage

// ---- sfpc_regmem.sv ----
// Small register memory holding the sticky control word.
// Assumes one writer port and one read port, read data registered.
`timescale 1ns/1ps
module sfpc_regmem (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [sfpc_pkg::SFPC_REG_AW-1:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [sfpc_pkg::SFPC_REG_AW-1:0] raddr,
  output logic [31:0] rdata,
  output logic [31:0] ctl
);
  import sfpc_pkg::*;

  logic [31:0] mem_reg [SFPC_REG_DEPTH];

  // Word store, cleared by reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < SFPC_REG_DEPTH; i++) begin
        mem_reg[i] <= 32'h0000_0000;
      end
    end else if (we) begin
      mem_reg[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= mem_reg[raddr];
    end
  end

  assign ctl = mem_reg[0];
endmodule

// ---- sfpc_top.sv ----
// Global forwarding policy of a packet switch: control register and decisions.
// Assumes an AHB-Lite master and a packet classifier presenting one header per cycle.
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module sfpc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pkt_valid,
  input wire logic [sfpc_pkg::SFPC_PORT_W-1:0] pkt_src_port,
  input wire logic [sfpc_pkg::SFPC_PORT_W-1:0] pkt_dst_port,
  input wire logic pkt_is_cfg,
  input wire logic pkt_is_cpl,
  input wire logic pkt_id_routed,
  input wire logic [4:0] pkt_dev_num,
  input wire logic pkt_to_up_bus,
  input wire logic pkt_to_dn_bus,
  input wire logic pkt_relaxed,
  input wire logic pkt_locked,
  input wire logic pkt_vendor_bcast,
  input wire logic [sfpc_pkg::SFPC_NPORTS-1:0] alt_routing_fwd_en,
  input wire logic hot_reset_start,
  output logic dec_valid,
  output logic [1:0] dec_verdict,
  output logic dec_relaxed,
  output logic dec_lock_effect,
  output logic dec_credit_return,
  output logic dec_err_log,
  output logic store_and_forward,
  output logic hot_reset_busy,
  output logic serial_load_req
);
  import sfpc_pkg::*;

  logic [31:0] ctl;
  logic [31:0] mem_rdata;
  logic ap_write_reg;
  logic ap_read_reg;
  logic [1:0] ap_idx_reg;
  logic ap_valid;
  logic wr_en;
  logic [1:0] wr_idx;
  logic [31:0] wr_data;
  logic rd_stat_reg;
  logic rd_cnt_reg;
  logic rd_mem_reg;
  logic [15:0] drop_cnt_reg;
  logic [15:0] ur_cnt_reg;
  sfpc_hr_t hr_state_reg;
  sfpc_hr_t hr_state_next;
  sfpc_verdict_t verdict;
  logic relaxed_ok;

  // Control fields, as views of the sticky control word
  // Reserved bits are never stored, so no field can pick one up
  logic init_skip;
  logic ordering_relax_disable;
  logic peer_traffic_disable;
  logic [1:0] downstream_devnum_check;
  logic upstream_id_check_en;
  logic cut_through_disable;
  logic lock_ignore;
  logic vendor_broadcast_drop;

  assign init_skip = ctl[SFPC_INIT_SKIP_BIT];
  assign ordering_relax_disable = ctl[SFPC_RO_DIS_BIT];
  assign peer_traffic_disable = ctl[SFPC_P2P_DIS_BIT];
  assign downstream_devnum_check = ctl[SFPC_DEVNUM_LSB+:2];
  assign upstream_id_check_en = ctl[SFPC_UPID_BIT];
  assign cut_through_disable = ctl[SFPC_CT_DIS_BIT];
  assign lock_ignore = ctl[SFPC_LOCK_IGN_BIT];
  assign vendor_broadcast_drop = ctl[SFPC_BCAST_BIT];

  // Address decode to a register index; 3 means unmapped
  // Exact match on the whole address, so aliases and unaligned bytes are unmapped
  function automatic logic [1:0] addr_index(input logic [31:0] a);
    if (a == SFPC_CTL_ADDR) begin
      addr_index = 2'h0;
    end else if (a == SFPC_STAT_ADDR) begin
      addr_index = 2'h1;
    end else if (a == SFPC_CNT_ADDR) begin
      addr_index = 2'h2;
    end else begin
      addr_index = 2'h3;
    end
  endfunction

  // Bus slave: zero wait states, always OKAY
  // Only NONSEQ and SEQ start a transfer; IDLE and BUSY cycles pass unseen
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ap_valid = hsel && hready && (htrans == SFPC_HTRANS_NONSEQ || htrans == SFPC_HTRANS_SEQ);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write_reg <= 1'b0;
      ap_read_reg <= 1'b0;
      ap_idx_reg <= 2'h0;
    end else begin
      ap_write_reg <= ap_valid && hwrite;
      ap_read_reg <= ap_valid && !hwrite;
      ap_idx_reg <= addr_index(haddr);
    end
  end

  // Only the control word is writable, and only its defined fields
  // The write lands at the end of the data phase, when hwdata is valid
  assign wr_en = ap_write_reg && (ap_idx_reg == 2'h0);
  assign wr_idx = 2'h0;
  assign wr_data = hwdata & SFPC_CTL_WMASK;

  // The read port is addressed in the address phase so the word arrives with the
  // data phase; a read right behind a write to the same word sees the old value
  sfpc_regmem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(wr_en),
    .waddr(wr_idx),
    .wdata(wr_data),
    .raddr(addr_index(haddr)),
    .rdata(mem_rdata),
    .ctl(ctl)
  );

  // Read source select, aligned with the registered read
  // Unmapped addresses select nothing and so read back as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_stat_reg <= 1'b0;
      rd_cnt_reg <= 1'b0;
      rd_mem_reg <= 1'b0;
    end else begin
      rd_stat_reg <= ap_valid && !hwrite && (addr_index(haddr) == 2'h1);
      rd_cnt_reg <= ap_valid && !hwrite && (addr_index(haddr) == 2'h2);
      rd_mem_reg <= ap_valid && !hwrite && (addr_index(haddr) == 2'h0);
    end
  end

  // Status and counter words; status bit 0 and the unused high bits stay zero
  logic [31:0] stat_word;
  logic [31:0] cnt_word;
  assign stat_word = {28'h0000000, store_and_forward, serial_load_req, hot_reset_busy, 1'b0};
  assign cnt_word = {ur_cnt_reg, drop_cnt_reg};

  // Read data mux; unmapped reads return zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_mem_reg) begin
      hrdata = mem_rdata & SFPC_CTL_WMASK;
    end else if (rd_stat_reg) begin
      hrdata = stat_word;
    end else if (rd_cnt_reg) begin
      hrdata = cnt_word;
    end
  end

  // Alternate routing enable for every encodable port number; numbers past the
  // last port read as disabled instead of indexing beyond the input
  logic [(1<<SFPC_PORT_W)-1:0] alt_en_port;
  for (genvar p = 0; p < (1 << SFPC_PORT_W); p++) begin : g_alt
    if (p < SFPC_NPORTS) begin : g_real
      assign alt_en_port[p] = alt_routing_fwd_en[p];
    end else begin : g_none
      assign alt_en_port[p] = 1'b0;
    end
  end

  // Packet verdict. Broadcast drop is judged first, then peer blocking, then the
  // upstream ID check and last the downstream device-number check, so a packet
  // caught by several controls still gets exactly one verdict and one count
  // Only a port without alternate routing applies the device-number check
  always_comb begin
    logic from_down;
    logic alt_en;
    logic dev_nz;
    from_down = (pkt_src_port != SFPC_UP_PORT);
    alt_en = alt_en_port[pkt_dst_port];
    dev_nz = (pkt_dev_num != 5'h00);
    verdict = SFPC_FWD;
    if (!from_down && pkt_vendor_bcast && vendor_broadcast_drop) begin
      verdict = SFPC_DROP;
    end else if (from_down && peer_traffic_disable && pkt_dst_port != SFPC_UP_PORT) begin
      verdict = SFPC_UR;
    end else if (from_down && pkt_to_up_bus && dev_nz && upstream_id_check_en) begin
      verdict = pkt_is_cpl ? SFPC_DROP : SFPC_UR;
    end else if (pkt_to_dn_bus && pkt_id_routed && dev_nz && !alt_en) begin
      case (downstream_devnum_check)
        SFPC_DN_ALL: begin
          verdict = pkt_is_cpl ? SFPC_DROP : SFPC_UR;
        end
        SFPC_DN_CFG: begin
          verdict = pkt_is_cfg ? SFPC_UR : SFPC_FWD;
        end
        default: begin
          verdict = SFPC_FWD;
        end
      endcase
    end
    // Nonzero device toward upstream bus with check off forwards normally
  end

  assign relaxed_ok = pkt_relaxed && !ordering_relax_disable;

  // Registered decision outputs
  // Every flag is qualified by pkt_valid so idle cycles show a clean forward verdict
  // A silent drop returns its credits and never raises the error flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_valid <= 1'b0;
      dec_verdict <= 2'h0;
      dec_relaxed <= 1'b0;
      dec_lock_effect <= 1'b0;
      dec_credit_return <= 1'b0;
      dec_err_log <= 1'b0;
    end else begin
      dec_valid <= pkt_valid;
      dec_verdict <= pkt_valid ? verdict : SFPC_FWD;
      dec_relaxed <= pkt_valid && relaxed_ok;
      dec_lock_effect <= pkt_valid && pkt_locked && !lock_ignore;
      dec_credit_return <= pkt_valid && (verdict == SFPC_DROP);
      dec_err_log <= pkt_valid && (verdict == SFPC_UR);
    end
  end

  // Forwarding mode follows the cut-through disable bit
  // A change applies to packets whose routing starts after the write has landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      store_and_forward <= 1'b0;
    end else begin
      store_and_forward <= cut_through_disable;
    end
  end

  // Drop and unsupported request counters, saturating
  // Saturation keeps a flood of bad traffic from wrapping back to a small count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drop_cnt_reg <= 16'h0000;
      ur_cnt_reg <= 16'h0000;
    end else if (pkt_valid) begin
      if (verdict == SFPC_DROP && drop_cnt_reg != 16'hffff) begin
        drop_cnt_reg <= drop_cnt_reg + 16'h0001;
      end
      if (verdict == SFPC_UR && ur_cnt_reg != 16'hffff) begin
        ur_cnt_reg <= ur_cnt_reg + 16'h0001;
      end
    end
  end

  // Hot reset sequence: one serial memory load step unless skipped, then one done
  // step before idle; a start request while a sequence runs is ignored, so a
  // second hot reset cannot cut a load short
  always_comb begin
    hr_state_next = hr_state_reg;
    case (hr_state_reg)
      SFPC_HR_IDLE: begin
        if (hot_reset_start) begin
          hr_state_next = init_skip ? SFPC_HR_DONE : SFPC_HR_LOAD;
        end
      end
      SFPC_HR_LOAD: begin
        hr_state_next = SFPC_HR_DONE;
      end
      default: begin
        hr_state_next = SFPC_HR_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hr_state_reg <= SFPC_HR_IDLE;
    end else begin
      hr_state_reg <= hr_state_next;
    end
  end

  // Sequence status outputs
  // Both levels come from the next state so they line up with the state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hot_reset_busy <= 1'b0;
      serial_load_req <= 1'b0;
    end else begin
      hot_reset_busy <= (hr_state_next != SFPC_HR_IDLE);
      serial_load_req <= (hr_state_next == SFPC_HR_LOAD);
    end
  end

  // Only whole words are mapped, so the transfer size is not decoded
  logic unused_ok;
  assign unused_ok = ^{hsize, ap_read_reg};
endmodule

// ---- sfpc_props.sv ----
// Checker for the forwarding policy block, bound to its top module.
// Assumes hready is tied to hreadyout and whole-word bus writes.
`timescale 1ns/1ps
module sfpc_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic pkt_valid,
  input wire logic [sfpc_pkg::SFPC_PORT_W-1:0] pkt_src_port,
  input wire logic [sfpc_pkg::SFPC_PORT_W-1:0] pkt_dst_port,
  input wire logic pkt_relaxed,
  input wire logic pkt_vendor_bcast,
  input wire logic hot_reset_start,
  input wire logic dec_valid,
  input wire logic [1:0] dec_verdict,
  input wire logic dec_relaxed,
  input wire logic dec_lock_effect,
  input wire logic dec_credit_return,
  input wire logic dec_err_log,
  input wire logic store_and_forward,
  input wire logic hot_reset_busy,
  input wire logic serial_load_req
);
  import sfpc_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_ph;
  logic [31:0] ctl_m;
  // Mirror of the control word from completed bus writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      ctl_m <= SFPC_CTL_RESET;
    end else if (hready) begin
      wr_ph <= hsel && htrans[1] && hwrite && haddr == SFPC_CTL_ADDR;
      if (wr_ph) ctl_m <= hwdata & SFPC_CTL_WMASK;
    end
  end
  property p_lat;
    1'b1 |=> dec_valid == $past(pkt_valid);
  endproperty
  a_lat: assert property (p_lat) else $error("decision latency wrong");
  property p_saf;
    1'b1 |=> store_and_forward == $past(ctl_m[SFPC_CT_DIS_BIT]);
  endproperty
  a_saf: assert property (p_saf) else $error("store and forward wrong");
  property p_ro;
    pkt_valid && ctl_m[SFPC_RO_DIS_BIT] |=> !dec_relaxed;
  endproperty
  a_ro: assert property (p_ro) else $error("relaxed despite disable");
  property p_rlx;
    pkt_valid && pkt_relaxed && !ctl_m[SFPC_RO_DIS_BIT] |=> dec_relaxed || dec_verdict != SFPC_FWD;
  endproperty
  a_rlx: assert property (p_rlx) else $error("relaxed attribute lost");
  property p_lock;
    pkt_valid && ctl_m[SFPC_LOCK_IGN_BIT] |=> !dec_lock_effect;
  endproperty
  a_lock: assert property (p_lock) else $error("lock effect kept");
  property p_bc;
    pkt_valid && pkt_src_port == SFPC_UP_PORT && pkt_vendor_bcast && ctl_m[SFPC_BCAST_BIT]
      |=> dec_verdict == SFPC_DROP;
  endproperty
  a_bc: assert property (p_bc) else $error("broadcast not dropped");
  property p_p2p;
    pkt_valid && ctl_m[SFPC_P2P_DIS_BIT] && pkt_src_port != SFPC_UP_PORT
      && pkt_dst_port != SFPC_UP_PORT |=> dec_verdict == SFPC_UR;
  endproperty
  a_p2p: assert property (p_p2p) else $error("peer traffic passed");
  property p_drop;
    dec_valid && dec_verdict == SFPC_DROP |-> dec_credit_return && !dec_err_log;
  endproperty
  a_drop: assert property (p_drop) else $error("drop not silent");
  property p_skip;
    hot_reset_start && !hot_reset_busy && ctl_m[SFPC_INIT_SKIP_BIT] |=> (!serial_load_req) [*2];
  endproperty
  a_skip: assert property (p_skip) else $error("load despite skip");
  property p_load;
    hot_reset_start && !hot_reset_busy && !ctl_m[SFPC_INIT_SKIP_BIT]
      |=> hot_reset_busy && serial_load_req ##1 !serial_load_req;
  endproperty
  a_load: assert property (p_load) else $error("load step missing");
  c_drop: cover property (dec_valid && dec_verdict == SFPC_DROP);
  c_ur: cover property (dec_valid && dec_verdict == SFPC_UR);
  c_saf: cover property ($rose(store_and_forward));
endmodule
bind sfpc_top sfpc_props chk_u (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .pkt_valid(pkt_valid),
  .pkt_src_port(pkt_src_port),
  .pkt_dst_port(pkt_dst_port),
  .pkt_relaxed(pkt_relaxed),
  .pkt_vendor_bcast(pkt_vendor_bcast),
  .hot_reset_start(hot_reset_start),
  .dec_valid(dec_valid),
  .dec_verdict(dec_verdict),
  .dec_relaxed(dec_relaxed),
  .dec_lock_effect(dec_lock_effect),
  .dec_credit_return(dec_credit_return),
  .dec_err_log(dec_err_log),
  .store_and_forward(store_and_forward),
  .hot_reset_busy(hot_reset_busy),
  .serial_load_req(serial_load_req)
);

// ---- sfpc_pkt_src.sv ----
// Header source standing in for the packet classifier beside the switch.
// Assumes the bench calls send from one process, one header per call.
`timescale 1ns/1ps
module sfpc_pkt_src (
  input wire logic hclk,
  output logic pkt_valid,
  output logic [18:0] hdr
);
  initial begin
    pkt_valid = 1'b0;
    hdr = 19'h0;
  end
  // One header for one cycle, fields scrambled while idle
  task automatic send(input logic [18:0] x);
    @(posedge hclk);
    pkt_valid <= 1'b1;
    hdr <= x;
    @(posedge hclk);
    pkt_valid <= 1'b0;
    hdr <= ~x;
  endtask
endmodule

// ---- tb_switch_forwarding_policy_ctl.sv ----
// Testbench for the forwarding policy block: bus tasks and header table.
// Assumes the zero-wait register slave and one-cycle decision latency.
`timescale 1ns/1ps
module tb_switch_forwarding_policy_ctl;
  import sfpc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hot_reset_start = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [5:0] alt_en = 6'h00;
  logic hreadyout, hresp, pkt_valid, dec_valid, store_and_forward, hot_reset_busy, serial_load_req;
  logic [18:0] hdr;
  wire [5:0] dec;
  int error_cnt = 0;
  int samples_checked = 0;
  always #50 hclk = ~hclk;
  sfpc_pkt_src src_u (.hclk(hclk), .pkt_valid(pkt_valid), .hdr(hdr));
  sfpc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pkt_valid(pkt_valid),
    .pkt_src_port(hdr[18:16]), .pkt_dst_port(hdr[15:13]), .pkt_is_cfg(hdr[12]),
    .pkt_is_cpl(hdr[11]), .pkt_id_routed(hdr[10]), .pkt_dev_num(hdr[9:5]),
    .pkt_to_up_bus(hdr[4]), .pkt_to_dn_bus(hdr[3]), .pkt_relaxed(hdr[2]),
    .pkt_locked(hdr[1]), .pkt_vendor_bcast(hdr[0]), .alt_routing_fwd_en(alt_en),
    .hot_reset_start(hot_reset_start), .dec_valid(dec_valid), .dec_verdict(dec[5:4]),
    .dec_relaxed(dec[3]), .dec_lock_effect(dec[2]), .dec_credit_return(dec[1]),
    .dec_err_log(dec[0]), .store_and_forward(store_and_forward),
    .hot_reset_busy(hot_reset_busy), .serial_load_req(serial_load_req));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t ns: got %h want %h", $time, g, e);
    end
  endtask
  // One single AHB transfer; read data kept in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= SFPC_HTRANS_NONSEQ;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Control word, header, expected decision under mask; bit 31 also enables ARI
  task automatic pk(input logic [31:0] c, input logic [18:0] h, input logic [5:0] e, m);
    bus(1'b1, SFPC_CTL_ADDR, c);
    alt_en <= {6{c[31]}};
    src_u.send(h);
    #1;
    chk({26'h0, dec & m}, {26'h0, e});
    chk({31'h0, dec_valid}, 32'h1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge hclk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, SFPC_CTL_ADDR, 32'h0);
    chk(rd, SFPC_CTL_RESET);
    bus(1'b1, SFPC_CTL_ADDR, 32'hffff_ffff);
    bus(1'b0, SFPC_CTL_ADDR, 32'h0);
    chk(rd, 32'h0008_cfc0);
    bus(1'b0, 32'h0000_000c, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, SFPC_CTL_ADDR, 32'h0000_4000);
    repeat (2) @(posedge hclk);
    bus(1'b0, SFPC_STAT_ADDR, 32'h0);
    chk(rd & 32'h8, 32'h8);
    bus(1'b1, SFPC_CTL_ADDR, 32'h0);
    repeat (2) @(posedge hclk);
    bus(1'b0, SFPC_STAT_ADDR, 32'h0);
    chk(rd & 32'h8, 32'h0);
    $display("register test done");
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, SFPC_CTL_ADDR, 32'(i) << 6);
      hot_reset_start <= 1'b1;
      @(posedge hclk);
      hot_reset_start <= 1'b0;
      #1;
      chk({30'h0, hot_reset_busy, serial_load_req}, {30'h0, 1'b1, i == 0});
      repeat (4) @(posedge hclk);
    end
    $display("hot reset test done");
    pk(32'h0, 19'h10004, 6'h08, 6'h3c);
    pk(32'h80, 19'h10004, 6'h00, 6'h3c);
    pk(32'h0, 19'h10002, 6'h04, 6'h34);
    pk(32'h8000, 19'h10002, 6'h00, 6'h34);
    pk(32'h100, 19'h14000, 6'h10, 6'h30);
    pk(32'h80000, 19'h02001, 6'h22, 6'h33);
    pk(32'h0, 19'h02001, 6'h00, 6'h30);
    pk(32'h800, 19'h10470, 6'h10, 6'h30);
    pk(32'h0, 19'h10470, 6'h00, 6'h30);
    pk(32'h800, 19'h10c70, 6'h22, 6'h33);
    pk(32'h0, 19'h03448, 6'h10, 6'h30);
    pk(32'h0, 19'h02448, 6'h10, 6'h30);
    pk(32'h200, 19'h02448, 6'h00, 6'h30);
    pk(32'h400, 19'h03448, 6'h00, 6'h30);
    pk(32'h0, 19'h03408, 6'h00, 6'h30);
    pk(32'h8000_0000, 19'h03448, 6'h00, 6'h30);
    bus(1'b0, SFPC_CNT_ADDR, 32'h0);
    chk(rd, 32'h0004_0002);
    $display("packet test done");
    results();
  end
endmodule
